// ==== adc_port_defs.svh ====
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH

// Frame positions, counted in serial clock falling edges
`define ADDR_BITS 4
`define CTRL_WIDTH 12
`define GAIN_WIDTH 7
`define RESULT_WIDTH 14
`define LAST_DATA_EDGE 6'd16
`define COMMIT_EDGE 6'd17
`define FIRST_OUT_EDGE 6'd19
`define SECOND_OUT_EDGE 6'd33
`define OUT_END_EDGE 6'd47
`define GAIN_CAPTURE_EDGE 6'd11

// Write address / read select codes
`define ADDR_CONV_RESULT 4'h0
`define ADDR_CONTROL 4'h1
`define ADDR_OFFSET_A 4'h2
`define ADDR_OFFSET_B 4'h3
`define ADDR_GAIN_A 4'h4
`define ADDR_GAIN_B 4'h5

// Control register fields
`define READ_SEL_MSB 11
`define READ_SEL_LSB 8
`define CAL_BIT 7
`define PD_MSB 6
`define PD_LSB 4
`define GAIN_MSB 3
`define GAIN_LSB 0
`define CTRL_RESET 12'h000
`define GAIN_RESERVED 4'hf
`define GAIN_SOFTWARE 4'h0

`endif

// ==== adc_port_pkg.sv ====
package adc_port_pkg;
    typedef enum logic [2:0] {
        PD_ALL_OFF = 3'h0,
        PD_ADC_ONLY = 3'h1,
        PD_FAST_CMP = 3'h2,
        PD_LOW_CMP = 3'h3,
        PD_ALL_CMP = 3'h4,
        PD_ALL_ON = 3'h5,
        PD_RSVD6 = 3'h6,
        PD_PIN_RESET = 3'h7
    } power_mode_t;

    typedef enum logic [3:0] {
        FRAME_IDLE = 4'b0001,
        FRAME_CONVERT = 4'b0010,
        FRAME_SHIFT = 4'b0100,
        FRAME_DONE = 4'b1000
    } frame_state_t;

    typedef logic [7:0] gain_factor_t;
endpackage

// ==== reg_store.sv ====
`timescale 1ns/1ps
`include "adc_port_defs.svh"

// Offset and gain register store with registered read data.
module reg_store (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wrEn,
    input wire logic [3:0] wrAddr,
    input wire logic [11:0] wrData,
    input wire logic calEn,
    input wire logic [11:0] calOffsetA,
    input wire logic [11:0] calOffsetB,
    input wire logic [3:0] rdAddr,
    output logic [11:0] rdData,
    output logic [11:0] offsetA,
    output logic [11:0] offsetB
);
    logic [6:0] gainA_q;
    logic [6:0] gainB_q;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            offsetA <= 12'h000;
            offsetB <= 12'h000;
            gainA_q <= 7'h00;
            gainB_q <= 7'h00;
        end else if (calEn) begin
            offsetA <= calOffsetA;
            offsetB <= calOffsetB;
        end else if (wrEn) begin
            case (wrAddr)
                `ADDR_OFFSET_A: offsetA <= wrData;
                `ADDR_OFFSET_B: offsetB <= wrData;
                // Gain data are the first seven bits after the address
                `ADDR_GAIN_A: gainA_q <= wrData[11:5];
                `ADDR_GAIN_B: gainB_q <= wrData[11:5];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData <= 12'h000;
        end else begin
            case (rdAddr)
                `ADDR_OFFSET_A: rdData <= offsetA;
                `ADDR_OFFSET_B: rdData <= offsetB;
                `ADDR_GAIN_A: rdData <= {5'h00, gainA_q};
                `ADDR_GAIN_B: rdData <= {5'h00, gainB_q};
                default: rdData <= 12'h000;
            endcase
        end
    end
endmodule // reg_store

// ==== adc_serial_port.sv ====
// What this block does
// - All gain pins low selects serial control mode
// - Sample data-in on falling clock, select low
// - Four address, twelve data, commit edge 17
// - Address 0001 selects control register
// - Fields: read select, cal, power, gain
// - Reset clears control, offset, gain registers
// - Calibration bit starts offset calibration
// - Control/offset twelve bits, gain seven bits
// - Gain write stores seven bits after address
// - New configuration applies to next conversion
// - Register read drives output A edge 19
// - Select fall samples, outputs float converting
// - Result MSB edge 19, LSB edge 32
// - Select rising floats both outputs
// - Held low: other result, float edge 47
// - Clock fall coinciding with select ignored
// - Gain codes map to fourteen gains
// - Power-down codes decode component enables
`timescale 1ns/1ps
`include "adc_port_defs.svh"

module adc_serial_port (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic chipSelN,
    input wire logic serialClk,
    input wire logic [3:0] gainSelectPin,
    input wire logic config_data_in,
    input wire logic [13:0] convResultA,
    input wire logic [13:0] convResultB,
    input wire logic [11:0] calMeasureA,
    input wire logic [11:0] calMeasureB,
    output logic result_out_a,
    output logic result_out_a_oe_n,
    output logic result_out_b,
    output logic result_out_b_oe_n,
    output logic sampleHold,
    output logic calibrating,
    output adc_port_pkg::power_mode_t power_down_select,
    output logic [3:0] gain_select,
    output adc_port_pkg::gain_factor_t gainFactor,
    output logic adcPowered,
    output logic fastCmpPowered,
    output logic lowCmpPowered,
    output logic controlMode,
    output logic [11:0] offsetA,
    output logic [11:0] offsetB
);
    import adc_port_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] csSync_q;
    logic [1:0] sclkSync_q;
    logic [1:0] dinSync_q;
    logic [3:0] gainPinMeta_q;
    logic [3:0] gainPinSync_q;
    logic csPrev_q;
    logic sclkPrev_q;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            csSync_q <= 2'b11;
            sclkSync_q <= 2'b11;
            dinSync_q <= 2'b00;
            gainPinMeta_q <= 4'h0;
            gainPinSync_q <= 4'h0;
            csPrev_q <= 1'b1;
            sclkPrev_q <= 1'b1;
        end else begin
            csSync_q <= {csSync_q[0], chipSelN};
            sclkSync_q <= {sclkSync_q[0], serialClk};
            dinSync_q <= {dinSync_q[0], config_data_in};
            gainPinMeta_q <= gainSelectPin;
            gainPinSync_q <= gainPinMeta_q;
            csPrev_q <= csSync_q[1];
            sclkPrev_q <= sclkSync_q[1];
        end
    end

    logic csLow;
    logic csFall;
    logic csRise;
    logic sclkFall;
    assign csLow = ~csSync_q[1];
    assign csFall = csPrev_q & ~csSync_q[1];
    assign csRise = ~csPrev_q & csSync_q[1];
    // A clock fall in the same cycle as the select fall is not counted
    assign sclkFall = sclkPrev_q & ~sclkSync_q[1] & csLow & ~csFall;
    assign controlMode = (gainPinSync_q == 4'h0);

    // ------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------
    frame_state_t state_q;
    logic [5:0] edgeCnt_q;
    logic [5:0] edgeNext;
    assign edgeNext = edgeCnt_q + 6'd1;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= FRAME_IDLE;
            edgeCnt_q <= 6'd0;
        end else if (csRise) begin
            state_q <= FRAME_IDLE;
            edgeCnt_q <= 6'd0;
        end else if (csFall) begin
            state_q <= FRAME_CONVERT;
            edgeCnt_q <= 6'd0;
        end else if (sclkFall) begin
            case (state_q)
                FRAME_CONVERT: begin
                    edgeCnt_q <= edgeNext;
                    if (edgeNext == `FIRST_OUT_EDGE) begin
                        state_q <= FRAME_SHIFT;
                    end
                end
                FRAME_SHIFT: begin
                    edgeCnt_q <= edgeNext;
                    if (edgeNext == `OUT_END_EDGE) begin
                        state_q <= FRAME_DONE;
                    end
                end
                FRAME_DONE: ;
                default: state_q <= FRAME_IDLE;
            endcase
        end
    end

    assign sampleHold = (state_q == FRAME_CONVERT);

    // ------------------------------------------------------------
    // Serial input shift register
    // ------------------------------------------------------------
    logic [15:0] shift_q;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_q <= 16'h0000;
        end else if (sclkFall && edgeCnt_q < `LAST_DATA_EDGE
                     && state_q == FRAME_CONVERT) begin
            shift_q <= {shift_q[14:0], dinSync_q[1]};
        end
    end

    logic commit;
    logic [3:0] wrAddr;
    assign wrAddr = shift_q[15:12];
    // The seventeenth edge commits the frame's write
    assign commit = sclkFall && edgeNext == `COMMIT_EDGE
                    && state_q == FRAME_CONVERT && controlMode;

    // ------------------------------------------------------------
    // Control register; takes effect at the next frame start
    // ------------------------------------------------------------
    logic [11:0] ctrl_q;
    logic [11:0] ctrlActive_q;
    logic [3:0] gainKeep_q;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= `CTRL_RESET;
        end else if (commit && wrAddr == `ADDR_CONTROL) begin
            ctrl_q <= shift_q[11:0];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlActive_q <= `CTRL_RESET;
        end else if (csFall) begin
            ctrlActive_q <= ctrl_q;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gainKeep_q <= 4'h1;
        end else if (csFall) begin
            if (!controlMode) begin
                gainKeep_q <= gainPinSync_q;
            end else if (ctrl_q[`GAIN_MSB:`GAIN_LSB] != `GAIN_RESERVED
                         && ctrl_q[`GAIN_MSB:`GAIN_LSB]
                            != `GAIN_SOFTWARE) begin
                gainKeep_q <= ctrl_q[`GAIN_MSB:`GAIN_LSB];
            end else if (ctrl_q[`GAIN_MSB:`GAIN_LSB] == `GAIN_SOFTWARE) begin
                // Cleared register means the power-up gain of one
                gainKeep_q <= 4'h1;
            end
        end
    end

    assign gain_select = gainKeep_q;
    assign power_down_select =
        power_mode_t'(ctrlActive_q[`PD_MSB:`PD_LSB]);

    always_comb begin
        case (gainKeep_q)
            4'h1: gainFactor = 8'd1;
            4'h2: gainFactor = 8'd2;
            4'h3: gainFactor = 8'd3;
            4'h4: gainFactor = 8'd4;
            4'h5: gainFactor = 8'd6;
            4'h6: gainFactor = 8'd8;
            4'h7: gainFactor = 8'd12;
            4'h8: gainFactor = 8'd16;
            4'h9: gainFactor = 8'd24;
            4'ha: gainFactor = 8'd32;
            4'hb: gainFactor = 8'd48;
            4'hc: gainFactor = 8'd64;
            4'hd: gainFactor = 8'd96;
            4'he: gainFactor = 8'd128;
            default: gainFactor = 8'd1;
        endcase
    end

    always_comb begin
        adcPowered = 1'b0;
        fastCmpPowered = 1'b0;
        lowCmpPowered = 1'b0;
        case (power_down_select)
            PD_ADC_ONLY: adcPowered = 1'b1;
            PD_FAST_CMP: fastCmpPowered = 1'b1;
            PD_LOW_CMP: lowCmpPowered = 1'b1;
            PD_ALL_CMP: begin
                fastCmpPowered = 1'b1;
                lowCmpPowered = 1'b1;
            end
            PD_ALL_ON: begin
                adcPowered = 1'b1;
                fastCmpPowered = 1'b1;
                lowCmpPowered = 1'b1;
            end
            default: ;
        endcase
    end

    // Calibration runs over the conversion phase of the frame started with the bit set
    assign calibrating = ctrlActive_q[`CAL_BIT] && state_q == FRAME_CONVERT;

    logic calDone;
    assign calDone = calibrating && sclkFall
                     && edgeNext == `FIRST_OUT_EDGE;

    // ------------------------------------------------------------
    // Offset and gain registers
    // ------------------------------------------------------------
    logic [11:0] regRdData;

    reg_store u_store (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wrEn(commit),
        .wrAddr(wrAddr),
        .wrData(shift_q[11:0]),
        .calEn(calDone),
        .calOffsetA(calMeasureA),
        .calOffsetB(calMeasureB),
        .rdAddr(ctrlActive_q[`READ_SEL_MSB:`READ_SEL_LSB]),
        .rdData(regRdData),
        .offsetA(offsetA),
        .offsetB(offsetB)
    );

    // ------------------------------------------------------------
    // Result shifters
    // ------------------------------------------------------------
    logic [27:0] outA_q;
    logic [27:0] outB_q;
    logic driving_q;
    logic readReg;
    assign readReg =
        ctrlActive_q[`READ_SEL_MSB:`READ_SEL_LSB] != `ADDR_CONV_RESULT;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            outA_q <= 28'h0;
            outB_q <= 28'h0;
            driving_q <= 1'b0;
        end else if (csRise) begin
            driving_q <= 1'b0;
        end else if (sclkFall) begin
            if (state_q == FRAME_CONVERT && edgeNext == `FIRST_OUT_EDGE) begin
                driving_q <= 1'b1;
                if (readReg) begin
                    outA_q <= {regRdData, 2'b00, convResultB};
                end else begin
                    outA_q <= {convResultA, convResultB};
                end
                outB_q <= {convResultB, convResultA};
            end else if (state_q == FRAME_SHIFT) begin
                outA_q <= {outA_q[26:0], 1'b0};
                outB_q <= {outB_q[26:0], 1'b0};
                if (edgeNext == `OUT_END_EDGE) begin
                    driving_q <= 1'b0;
                end
            end
        end else if (csFall) begin
            driving_q <= 1'b0;
        end
    end

    assign result_out_a = outA_q[27];
    assign result_out_b = outB_q[27];
    assign result_out_a_oe_n = ~driving_q;
    assign result_out_b_oe_n = ~driving_q;
endmodule // adc_serial_port

// ==== adc_port_chk.sv ====
`timescale 1ns/1ps
module adc_port_chk (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic chipSelN,
    input wire logic [3:0] gainSelectPin,
    input wire logic result_out_a_oe_n,
    input wire logic result_out_b_oe_n,
    input wire logic sampleHold,
    input wire logic calibrating,
    input wire adc_port_pkg::power_mode_t power_down_select,
    input wire logic [3:0] gain_select,
    input wire adc_port_pkg::gain_factor_t gainFactor,
    input wire logic adcPowered,
    input wire logic fastCmpPowered,
    input wire logic lowCmpPowered,
    input wire logic controlMode,
    input wire logic [11:0] offsetA,
    input wire logic [11:0] offsetB
);
    import adc_port_pkg::*;
    localparam logic [7:0] GTAB [0:15] = '{8'h00, 8'h01, 8'h02, 8'h03,
        8'h04, 8'h06, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h20, 8'h30, 8'h40,
        8'h60, 8'h80, 8'h00};
    // Order is adc, fast, low
    localparam logic [2:0] PTAB [0:7] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h3,
        3'h7, 3'h0, 3'h0};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence holdEnd;
        $fell(sampleHold) && !chipSelN;
    endsequence
    sequence bothDrive;
        !result_out_a_oe_n && !result_out_b_oe_n;
    endsequence
    a_oe_paired:
    assert property (result_out_a_oe_n == result_out_b_oe_n)
        else $error("output enables differ");
    a_convert_float:
    assert property ($rose(sampleHold) |=>
        (result_out_a_oe_n && result_out_b_oe_n)[*8])
        else $error("output driven during conversion");
    a_hold_start:
    assert property ($fell(chipSelN) |-> ##[1:6] sampleHold)
        else $error("select fall did not start conversion");
    a_float_idle:
    assert property (chipSelN[*6] |->
        result_out_a_oe_n && result_out_b_oe_n)
        else $error("output driven with select high");
    a_enable_edge:
    assert property (holdEnd |-> ##[0:3] bothDrive)
        else $error("outputs not enabled after conversion");
    a_gain_map:
    assert property ($stable(gain_select) &&
        gain_select inside {[4'h1:4'he]} |->
        gainFactor == GTAB[gain_select])
        else $error("gain factor wrong");
    a_pd_decode:
    assert property ($stable(power_down_select) &&
        power_down_select <= PD_ALL_ON |-> {adcPowered,
        fastCmpPowered, lowCmpPowered} == PTAB[power_down_select])
        else $error("power enables wrong");
    a_gain_rsv:
    assert property (gain_select != 4'hf)
        else $error("reserved gain code active");
    a_mode_pins:
    assert property ($stable(gainSelectPin)[*5] |->
        controlMode == (gainSelectPin == 4'h0))
        else $error("control mode wrong");
    a_cfg_frame:
    assert property (controlMode && $past(controlMode, 3) &&
        $changed(power_down_select) |-> !chipSelN)
        else $error("config changed outside a frame");
    a_offset_frame:
    assert property ($changed({offsetA, offsetB}) |-> !chipSelN)
        else $error("offset changed outside a frame");
    a_cal_load:
    assert property ($fell(calibrating) && !chipSelN |->
        $changed({offsetA, offsetB}))
        else $error("calibration did not load offsets");
endmodule // adc_port_chk

bind adc_serial_port adc_port_chk i_chk (.*);

// ==== host_model.sv ====
`timescale 1ns/1ps
module host_model (
    input wire logic core_clk,
    output logic chipSelN,
    output logic serialClk,
    output logic config_data_in,
    input wire logic result_out_a,
    input wire logic result_out_b,
    input wire logic result_out_a_oe_n,
    input wire logic result_out_b_oe_n
);
    // Synchroniser needs at least 4 core cycles per half period
    localparam int HALF = 8;
    // Power-down pins one and two are not modelled: held low
    initial begin
        chipSelN = 1'b1;
        serialClk = 1'b1;
        config_data_in = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Word is write address then data, both MSB first
    task automatic xfer(input logic [15:0] w, input int n, input bit coin,
            output logic [27:0] ra, output logic [27:0] rb,
            output logic oeEnd);
        ra = 'x;
        rb = 'x;
        chipSelN = 1'b0;
        serialClk = !coin;
        config_data_in = w[15];
        step(HALF);
        serialClk = 1'b1;
        if (coin) step(HALF);
        for (int k = 1; k <= n; k++) begin
            if (k >= 20) begin
                ra[47 - k] = result_out_a;
                rb[47 - k] = result_out_b;
            end
            serialClk = 1'b0;
            step(HALF);
            serialClk = 1'b1;
            config_data_in = (k < 16) ? w[15 - k] : 1'b0;
            step(HALF);
        end
        if (n < 47) chipSelN = 1'b1;
        step(HALF);
        oeEnd = result_out_a_oe_n & result_out_b_oe_n;
        chipSelN = 1'b1;
        config_data_in = !config_data_in;
        step(HALF);
    endtask
endmodule // host_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import adc_port_pkg::*;
    logic core_clk, sys_rst, chipSelN, serialClk, config_data_in;
    logic [3:0] gainSelectPin, gain_select;
    logic [13:0] convResultA, convResultB;
    logic [11:0] calMeasureA, calMeasureB, offsetA, offsetB;
    logic result_out_a, result_out_a_oe_n, result_out_b, result_out_b_oe_n;
    logic sampleHold, calibrating, adcPowered, fastCmpPowered;
    logic lowCmpPowered, controlMode, oeEnd;
    power_mode_t power_down_select;
    gain_factor_t gainFactor;
    logic [27:0] ra, rb;
    int mismatches, checked, cyc;
    logic [7:0] gtab [0:14] = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h04,
        8'h06, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h20, 8'h30, 8'h40, 8'h60,
        8'h80};
    logic [2:0] ptab [0:5] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h3, 3'h7};

    adc_serial_port i_dut (.*);
    host_model i_host (.*);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            end_sim();
        end
    end

    function automatic logic [15:0] ctrl(logic [3:0] rd, logic cal,
            logic [2:0] pd, logic [3:0] g);
        return {4'h1, rd, cal, pd, g};
    endfunction
    task automatic cmp(input logic [27:0] got, input logic [27:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic frame(input logic [15:0] w, input int n);
        i_host.xfer(w, n, 1'b0, ra, rb, oeEnd);
    endtask
    task automatic end_sim();
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        gainSelectPin = 4'h0;
        convResultA = 14'h2d5b;
        convResultB = 14'h1a36;
        calMeasureA = 12'h3c7;
        calMeasureB = 12'h81e;
        i_host.step(8);
        sys_rst = 1'b0;
        i_host.step(4);
        cmp({result_out_a_oe_n, result_out_b_oe_n}, 2'h3);
        cmp({offsetA, offsetB, power_down_select}, 27'h0);
        cmp(gainFactor, 8'h01);
        for (int i = 1; i <= 16; i++) begin
            frame(ctrl(4'h0, 1'b0, 3'(i % 6), (i > 14) ? 4'hf : 4'(i)), 17);
            cmp(gainFactor, gtab[(i > 15) ? 14 : i - 1]);
            cmp({power_down_select, adcPowered, fastCmpPowered,
                lowCmpPowered}, {3'((i - 1) % 6), ptab[(i - 1) % 6]});
        end
        i_host.xfer(ctrl(4'h0, 1'b0, 3'h5, 4'h3), 47, 1'b1, ra, rb, oeEnd);
        cmp(ra, {convResultA, convResultB});
        cmp({oeEnd, rb}, {1'b1, convResultB, convResultA});
        frame(ctrl(4'h0, 1'b1, 3'h5, 4'h3), 33);
        cmp({gainFactor, power_down_select}, {8'h03, PD_ALL_ON});
        cmp({oeEnd, ra[27:14]}, {1'b1, convResultA});
        frame(ctrl(4'h0, 1'b0, 3'h5, 4'h3), 33);
        cmp({offsetA, offsetB}, {calMeasureA, calMeasureB});
        frame({4'h2, 12'ha5c}, 17);
        frame({4'h5, 7'h59, 5'h00}, 17);
        cmp(offsetA, 12'ha5c);
        frame(ctrl(4'h5, 1'b0, 3'h5, 4'h3), 17);
        frame(ctrl(4'h2, 1'b0, 3'h5, 4'h3), 33);
        cmp(ra[27:14], {12'h059, 2'h0});
        frame(ctrl(4'h0, 1'b0, 3'h5, 4'h3), 33);
        cmp(ra[27:14], {12'ha5c, 2'h0});
        gainSelectPin = 4'h6;
        i_host.step(4);
        cmp(controlMode, 1'b0);
        frame(ctrl(4'h0, 1'b0, 3'h0, 4'h1), 17);
        cmp(gainFactor, 8'h08);
        gainSelectPin = 4'h0;
        frame(ctrl(4'h0, 1'b0, 3'h5, 4'h3), 17);
        cmp({controlMode, power_down_select}, {1'b1, PD_ALL_ON});
        end_sim();
    end
endmodule // tb_top
